/* mfio_pkg.sv */
// Package for the multifunction I/O port block: offsets, field codes, carriers
package mfio_pkg;

	// ==========================================================
	// Register index within one port (per-port stride below)
	localparam logic [7:0] MFIO_REG_PIN_INPUT_LEVEL = 8'h00;
	localparam logic [7:0] MFIO_REG_PIN_OUTPUT_VALUE = 8'h04;
	localparam logic [7:0] MFIO_REG_PIN_DIRECTION = 8'h06;
	localparam logic [7:0] MFIO_REG_PIN_DRIVE_SELECT = 8'h08;
	localparam logic [7:0] MFIO_REG_INPUT_MACROCELL = 8'h0A;
	localparam logic [7:0] MFIO_REG_OUTPUT_MACROCELL = 8'h0C;
	localparam logic [7:0] MFIO_REG_PIN_OE_STATUS = 8'h0E;
	localparam logic [7:0] MFIO_PORT_STRIDE = 8'h10;
	localparam int MFIO_NUM_PORTS = 7;
	localparam logic [2:0] MFIO_PORT_D = 3'h3;
	localparam logic [2:0] MFIO_PORT_E = 3'h4;
	localparam logic [2:0] MFIO_PORT_F = 3'h5;
	localparam logic [2:0] MFIO_PORT_G = 3'h6;
	localparam logic [7:0] MFIO_PORT_D_MASK = 8'h0F;
	localparam logic [7:0] MFIO_RESET_VALUE = 8'h00;

	// ==========================================================
	// Static configuration codes
	localparam logic [1:0] MFIO_OSEL_DATA_OUT = 2'h0;
	localparam logic [1:0] MFIO_OSEL_MACROCELL = 2'h1;
	localparam logic [1:0] MFIO_OSEL_CHIP_SELECT = 2'h2;
	localparam logic [1:0] MFIO_IMC_DIRECT = 2'h0;
	localparam logic [1:0] MFIO_IMC_REGISTER = 2'h1;
	localparam logic [1:0] MFIO_IMC_LATCH = 2'h2;

	// ==========================================================
	// Host register access carrier
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mfio_host_req_t;

	// Per-pin static configuration carrier
	typedef struct packed {
		logic [1:0] out_sel;
		logic [1:0] imc_mode;
	} mfio_pin_cfg_t;

endpackage

/* mfio_ports.sv */
// Seven multifunction I/O ports with host-visible control registers
`timescale 1ns/10ps

// Operation
// - Pin input register reads the true level on each pin, bit n is pin n.
// - Output data bit drives its pin when the complex logic array does not.
// - Array-driven pins ignore output data writes; array output overrides.
// - Output data register is readable and writable at any time.
// - Direction bit one makes pin output, zero makes it input.
// - All pins default to input after reset.
// - Driver enable is array enable term OR direction bit.
// - Inactive array enable leaves direction bit in sole control.
// - Static config picks output data, output macrocell, or chip select on C.
// - Readback buffer puts exactly one selected source on the data bus.
// - Ports A-C inputs pass input macrocells: register, latch or direct; readable.
// - Drive select one gives open drain on supporting pins; default push-pull.
// - On other pins drive select one gives fast slew; default standard.
// - Output enable status register shows each pin's driver enable, taken before open-drain gating.
// - Seven ports A-G, eight pins each, port D four pins.
// - Port F carries host data 0-7; port G data 8-15 in 16-bit mode.
// - Port G host I/O only in 8-bit mode; port F never.
// - Port D feeds the arrays directly, without input macrocells.
// - Port A from macrocell bank A, B from bank B, C from chip selects.
// - Some port E pins serve programming, multiplexed with other I/O.
module mfio_ports
	import mfio_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire mfio_host_req_t host_req,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	input wire logic bus_16bit,
	input wire logic [15:0] host_bus_out,
	input wire logic host_bus_oe,
	output logic [15:0] host_bus_in,
	input wire mfio_pin_cfg_t [MFIO_NUM_PORTS-1:0][7:0] pin_cfg,
	input wire logic [7:0] macrocell_bank_a,
	input wire logic [7:0] macrocell_bank_b,
	input wire logic [7:0] external_chip_selects,
	input wire logic [MFIO_NUM_PORTS-1:0][7:0] array_oe_term,
	input wire logic [2:0] imc_clock_term,
	output logic [2:0][7:0] input_macrocell_out,
	output logic [3:0] port_d_direct_in,
	input wire logic in_system_programming_en,
	input wire logic [7:0] isp_pin_mask,
	input wire logic [7:0] isp_out,
	input wire logic [7:0] isp_oe,
	output logic [7:0] isp_in,
	input wire logic [MFIO_NUM_PORTS-1:0][7:0] pin_in,
	output logic [MFIO_NUM_PORTS-1:0][7:0] pin_out,
	output logic [MFIO_NUM_PORTS-1:0][7:0] pin_oe_n,
	output logic [MFIO_NUM_PORTS-1:0][7:0] pin_fast_slew
);

	// ==========================================================
	// Register storage
	logic [MFIO_NUM_PORTS-1:0][7:0] pin_output_value;
	logic [MFIO_NUM_PORTS-1:0][7:0] pin_direction;
	logic [MFIO_NUM_PORTS-1:0][7:0] pin_drive_select;
	logic [2:0][7:0] imc_store;
	logic [MFIO_NUM_PORTS-1:0][7:0] drive_en;
	logic [MFIO_NUM_PORTS-1:0][7:0] mux_out;
	logic [MFIO_NUM_PORTS-1:0][7:0] pin_level;
	logic [MFIO_NUM_PORTS-1:0][7:0] port_mask;
	logic [MFIO_NUM_PORTS-1:0] host_io_ok;
	logic [MFIO_NUM_PORTS-1:0] open_drain_ok;
	logic [2:0] acc_port;
	logic [7:0] acc_reg;
	logic acc_hit;
	logic acc_ok;
	logic [2:0] acc_idx;
	logic [2:0] imc_term_prev;
	logic [2:0] imc_term_rise;
	logic [7:0] next_rdata;

	// ==========================================================
	// Address decode
	always_comb begin
		acc_port = host_req.addr[6:4];
		acc_reg = {4'h0, host_req.addr[3:0]};
		// Port numbers past G fall back to port A index 0 so no array is indexed out of range
		acc_ok = (host_req.addr[7] == 1'b0) && (acc_port < 3'(MFIO_NUM_PORTS));
		acc_idx = acc_ok ? acc_port : 3'h0;
		acc_hit = host_req.sel && acc_ok && host_io_ok[acc_idx];
	end

	// ==========================================================
	// Per-port capabilities
	always_comb begin
		for (int p = 0; p < MFIO_NUM_PORTS; p++) begin
			port_mask[p] = 8'hFF;
			host_io_ok[p] = 1'b1;
			open_drain_ok[p] = 1'b1;
		end
		port_mask[MFIO_PORT_D] = MFIO_PORT_D_MASK;
		host_io_ok[MFIO_PORT_F] = 1'b0;
		host_io_ok[MFIO_PORT_G] = ~bus_16bit;
		open_drain_ok[2] = 1'b0;
		open_drain_ok[MFIO_PORT_D] = 1'b0;
		open_drain_ok[MFIO_PORT_F] = 1'b0;
	end

	// ==========================================================
	// Writable registers; F and G refuse writes while owned by the bus
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pin_output_value <= '0;
			pin_direction <= '0;
			pin_drive_select <= '0;
		end else if (acc_hit && host_req.wr) begin
			unique case (acc_reg)
				MFIO_REG_PIN_OUTPUT_VALUE: begin
					pin_output_value[acc_idx] <= host_req.wdata & port_mask[acc_idx];
				end
				MFIO_REG_PIN_DIRECTION: begin
					pin_direction[acc_idx] <= host_req.wdata & port_mask[acc_idx];
				end
				MFIO_REG_PIN_DRIVE_SELECT: begin
					pin_drive_select[acc_idx] <= host_req.wdata & port_mask[acc_idx];
				end
				default: begin
					// Read-only and unmapped offsets ignore writes
				end
			endcase
		end
	end

	// ==========================================================
	// Input macrocells on ports A-C
	// Term history; reset low matches the idle term, so no false edge follows
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			imc_term_prev <= '0;
		end else begin
			imc_term_prev <= imc_clock_term;
		end
	end

	assign imc_term_rise = imc_clock_term & ~imc_term_prev;

	// Register mode samples once per rising term; latch mode tracks the pin
	// while the term is high and keeps the last level once the term falls.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			imc_store <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				for (int b = 0; b < 8; b++) begin
					if (pin_cfg[p][b].imc_mode == MFIO_IMC_REGISTER) begin
						if (imc_term_rise[p]) begin
							imc_store[p][b] <= pin_level[p][b];
						end
					end else if (pin_cfg[p][b].imc_mode == MFIO_IMC_LATCH) begin
						if (imc_clock_term[p]) begin
							imc_store[p][b] <= pin_level[p][b];
						end
					end
				end
			end
		end
	end

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (pin_cfg[p][b].imc_mode == MFIO_IMC_DIRECT) begin
					input_macrocell_out[p][b] = pin_level[p][b];
				end else if (pin_cfg[p][b].imc_mode == MFIO_IMC_LATCH && imc_clock_term[p]) begin
					// Open latch is transparent, with no clock of delay
					input_macrocell_out[p][b] = pin_level[p][b];
				end else begin
					input_macrocell_out[p][b] = imc_store[p][b];
				end
			end
		end
		port_d_direct_in = pin_level[MFIO_PORT_D][3:0];
	end

	// ==========================================================
	// Output mux and driver enable
	always_comb begin
		for (int p = 0; p < MFIO_NUM_PORTS; p++) begin
			for (int b = 0; b < 8; b++) begin
				mux_out[p][b] = pin_output_value[p][b];
				if (pin_cfg[p][b].out_sel == MFIO_OSEL_MACROCELL) begin
					if (p == 0) begin
						mux_out[p][b] = macrocell_bank_a[b];
					end else if (p == 1) begin
						mux_out[p][b] = macrocell_bank_b[b];
					end
				end else if (pin_cfg[p][b].out_sel == MFIO_OSEL_CHIP_SELECT && p == 2) begin
					mux_out[p][b] = external_chip_selects[b];
				end
				drive_en[p][b] = (array_oe_term[p][b] | pin_direction[p][b])
					& port_mask[p][b];
			end
		end
		// Data bus ports follow the host's own enable
		for (int b = 0; b < 8; b++) begin
			mux_out[MFIO_PORT_F][b] = host_bus_out[b];
			drive_en[MFIO_PORT_F][b] = host_bus_oe;
			if (bus_16bit) begin
				mux_out[MFIO_PORT_G][b] = host_bus_out[8+b];
				drive_en[MFIO_PORT_G][b] = host_bus_oe;
			end
			if (in_system_programming_en && isp_pin_mask[b]) begin
				mux_out[MFIO_PORT_E][b] = isp_out[b];
				drive_en[MFIO_PORT_E][b] = isp_oe[b];
			end
		end
	end

	// ==========================================================
	// Pin drivers: open drain drives only the low level
	always_comb begin
		for (int p = 0; p < MFIO_NUM_PORTS; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (open_drain_ok[p] && pin_drive_select[p][b]) begin
					pin_out[p][b] = 1'b0;
					pin_oe_n[p][b] = ~(drive_en[p][b] & ~mux_out[p][b]);
				end else begin
					pin_out[p][b] = mux_out[p][b];
					pin_oe_n[p][b] = ~drive_en[p][b];
				end
				pin_fast_slew[p][b] = ~open_drain_ok[p] & pin_drive_select[p][b];
				// Level seen at the pin, whoever drives it
				pin_level[p][b] = pin_in[p][b] & port_mask[p][b];
			end
		end
		host_bus_in = {pin_level[MFIO_PORT_G], pin_level[MFIO_PORT_F]};
		isp_in = pin_level[MFIO_PORT_E];
	end

	// ==========================================================
	// Readback buffer: one source per access
	always_comb begin
		next_rdata = 8'h00;
		unique case (acc_reg)
			MFIO_REG_PIN_INPUT_LEVEL: next_rdata = pin_level[acc_idx];
			MFIO_REG_PIN_OUTPUT_VALUE: next_rdata = pin_output_value[acc_idx];
			MFIO_REG_PIN_DIRECTION: next_rdata = pin_direction[acc_idx];
			MFIO_REG_PIN_DRIVE_SELECT: next_rdata = pin_drive_select[acc_idx];
			MFIO_REG_INPUT_MACROCELL: begin
				if (acc_idx < 3'h3) begin
					next_rdata = input_macrocell_out[acc_idx[1:0]];
				end
			end
			MFIO_REG_OUTPUT_MACROCELL: begin
				if (acc_idx == 3'h0) begin
					next_rdata = macrocell_bank_a;
				end else if (acc_idx == 3'h1) begin
					next_rdata = macrocell_bank_b;
				end else if (acc_idx == 3'h2) begin
					next_rdata = external_chip_selects;
				end
			end
			MFIO_REG_PIN_OE_STATUS: next_rdata = drive_en[acc_idx];
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			host_rdata <= MFIO_RESET_VALUE;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_req.sel && host_req.rd;
			if (host_req.sel && host_req.rd) begin
				host_rdata <= acc_hit ? next_rdata : 8'h00;
			end
		end
	end

endmodule // mfio_ports

/* mfio_ports_sva.sv */
// Concurrent checks on the host register path and pin enables
`timescale 1ns/10ps
module mfio_ports_sva
	import mfio_pkg::*;
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire mfio_host_req_t host_req,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid,
	input wire logic [MFIO_NUM_PORTS-1:0][7:0] array_oe_term,
	input wire logic [MFIO_NUM_PORTS-1:0][7:0] pin_in,
	input wire logic [MFIO_NUM_PORTS-1:0][7:0] pin_oe_n
);
	default clocking cb @(posedge core_clk); endclocking
	// ==========
	// Read request steps
	sequence any_rd;
		host_req.sel && host_req.rd;
	endsequence
	sequence rd_at(logic [7:0] a);
		host_req.sel && host_req.rd && host_req.addr == a;
	endsequence
	// ==========
	// Register answers
	read_answer_a: assert property (disable iff (!resetn) any_rd |=> host_rvalid)
		else $error("read not answered");
	spurious_answer_a: assert property (disable iff (!resetn)
		!(host_req.sel && host_req.rd) |=> !host_rvalid) else $error("answer without read");
	rdata_hold_a: assert property (disable iff (!resetn) !host_rvalid |-> $stable(host_rdata))
		else $error("read data moved");
	status_read_a: assert property (disable iff (!resetn) rd_at(MFIO_REG_PIN_OE_STATUS)
		|=> host_rdata == ~$past(pin_oe_n[0])) else $error("status wrong");
	level_read_a: assert property (disable iff (!resetn) rd_at(8'h10)
		|=> host_rdata == $past(pin_in[1])) else $error("pin level wrong");
	port_f_refused_a: assert property (disable iff (!resetn) rd_at(8'h54)
		|=> host_rdata == 8'h00) else $error("bus port readable");
	// ==========
	// Driver enables; no disable here so reset itself is covered
	array_enable_a: assert property ((array_oe_term[2] & pin_oe_n[2]) == 8'h00)
		else $error("array term not driving");
	reset_input_a: assert property (!resetn |-> pin_oe_n[1] == ~array_oe_term[1])
		else $error("pin driven in reset");
endmodule // mfio_ports_sva

bind mfio_ports mfio_ports_sva CHK (.core_clk, .resetn, .host_req, .host_rdata,
	.host_rvalid, .array_oe_term, .pin_in, .pin_oe_n);

/* mfio_host.sv */
// Host processor model issuing single register cycles
`timescale 1ns/10ps
module mfio_host
	import mfio_pkg::*;
(
	input wire logic core_clk,
	output mfio_host_req_t host_req
);
	initial host_req = '0;
	// Idle lines show the inverse so a stale address never matches
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		host_req <= '{sel: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
		@(negedge core_clk);
		host_req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
endmodule // mfio_host

/* mfio_ports_bench.sv */
// Self-checking bench for the multifunction I/O port block
`timescale 1ns/10ps
module mfio_ports_bench import mfio_pkg::*;;
	logic core_clk, resetn, bus_16bit, host_bus_oe, in_system_programming_en, host_rvalid;
	mfio_host_req_t host_req;
	logic [7:0] host_rdata, macrocell_bank_a, macrocell_bank_b, external_chip_selects;
	logic [7:0] isp_pin_mask, isp_out, isp_oe, isp_in;
	logic [15:0] host_bus_out, host_bus_in;
	mfio_pin_cfg_t [MFIO_NUM_PORTS-1:0][7:0] pin_cfg;
	logic [MFIO_NUM_PORTS-1:0][7:0] array_oe_term, pin_in, pin_out, pin_oe_n, pin_fast_slew;
	logic [2:0] imc_clock_term;
	logic [2:0][7:0] input_macrocell_out;
	logic [3:0] port_d_direct_in;
	logic [63:0] r;
	logic [7:0] q[$];
	logic [7:0] rr[8] = '{8'h04, 8'h06, 8'h08, 8'h0E, 8'h14, 8'h16, 8'h18, 8'h1E};
	integer seed, err_total, n_checks, cyc;

	mfio_host HOST (.core_clk, .host_req);
	mfio_ports DUT (.core_clk, .resetn, .host_req, .host_rdata, .host_rvalid, .bus_16bit,
		.host_bus_out, .host_bus_oe, .host_bus_in, .pin_cfg, .macrocell_bank_a,
		.macrocell_bank_b, .external_chip_selects, .array_oe_term, .imc_clock_term,
		.input_macrocell_out, .port_d_direct_in, .in_system_programming_en, .isp_pin_mask,
		.isp_out, .isp_oe, .isp_in, .pin_in, .pin_out, .pin_oe_n, .pin_fast_slew);

	// ==========
	// Shared tasks
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back(e);
		HOST.acc(1'b0, a, 8'h00);
	endtask
	task automatic end_of_test();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ==========
	// Clock, answer monitor and hang limit
	initial begin
		core_clk = 0;
		forever #50 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (host_rvalid === 1'b1) begin
			if (q.size() == 0) begin
				// An answer nobody asked for is a mismatch whatever it carries
				n_checks++;
				err_total++;
				$display("BAD t=%0t got=%h exp=%h", $time, host_rdata, 8'h00);
			end else
				chk(host_rdata, q.pop_front());
		end
	end
	initial begin
		cyc = 0;
		forever begin
			@(posedge core_clk);
			cyc++;
			if (cyc == 2000) begin
				err_total++;
				end_of_test();
			end
		end
	end

	// ==========
	// Main sequence
	initial begin
		seed = 83;
		err_total = 0;
		n_checks = 0;
		resetn = 0;
		{bus_16bit, host_bus_oe, in_system_programming_en, imc_clock_term} = '0;
		{host_bus_out, macrocell_bank_a, macrocell_bank_b, isp_pin_mask, isp_out, isp_oe} = '0;
		array_oe_term = '0;
		pin_cfg = '0;
		for (int i = 0; i < 8; i++) pin_cfg[2][i].out_sel = MFIO_OSEL_CHIP_SELECT;
		r = {$random(seed), $random(seed)};
		pin_in = r[55:0];
		external_chip_selects = r[63:56];
		repeat (4) @(negedge core_clk);
		resetn = 1;
		foreach (rr[i]) rd(rr[i], 8'h00);
		HOST.acc(1'b1, 8'h04, r[63:56]);
		HOST.acc(1'b1, 8'h06, 8'hFF);
		rd(8'h04, r[63:56]);
		rd(8'h0E, 8'hFF);
		chk(pin_out[0], r[63:56]);
		rd(8'h10, pin_in[1]);
		rd(8'h0A, pin_in[0]);
		chk({4'h0, port_d_direct_in}, {4'h0, pin_in[3][3:0]});
		chk(host_bus_in[7:0], pin_in[5]);
		chk(host_bus_in[15:8], pin_in[6]);
		// Register mode: one capture on the rising term, then the pin moves
		for (int i = 0; i < 8; i++) pin_cfg[1][i].imc_mode = MFIO_IMC_REGISTER;
		imc_clock_term[1] = 1'b1;
		@(negedge core_clk);
		imc_clock_term[1] = 1'b0;
		pin_in[1] = ~r[15:8];
		rd(8'h1A, r[15:8]);
		rd(8'h10, ~r[15:8]);
		// Latch mode: transparent before any edge, then holds once closed
		for (int i = 0; i < 8; i++) pin_cfg[2][i].imc_mode = MFIO_IMC_LATCH;
		imc_clock_term[2] = 1'b1;
		pin_in[2] = ~r[23:16];
		#10;
		chk(input_macrocell_out[2], ~r[23:16]);
		@(negedge core_clk);
		imc_clock_term[2] = 1'b0;
		pin_in[2] = r[23:16];
		rd(8'h2A, ~r[23:16]);
		rd(8'h20, r[23:16]);
		// Programming takeover of low port E pins, host drives port F
		in_system_programming_en = 1'b1;
		{isp_pin_mask, isp_out, isp_oe} = {8'h0F, 8'h05, 8'h0F};
		host_bus_oe = 1'b1;
		host_bus_out = 16'hA55A;
		@(negedge core_clk);
		chk(pin_out[4] & 8'h0F, 8'h05);
		chk(pin_oe_n[4], 8'hF0);
		chk(isp_in, pin_in[4]);
		chk(pin_out[5], 8'h5A);
		chk(pin_oe_n[5], 8'h00);
		array_oe_term[2] = 8'h0F;
		HOST.acc(1'b1, 8'h24, ~r[63:56]);
		chk(pin_out[2], external_chip_selects);
		rd(8'h2E, 8'h0F);
		HOST.acc(1'b1, 8'h28, 8'hFF);
		chk(pin_fast_slew[2], 8'hFF);
		HOST.acc(1'b1, 8'h36, 8'hFF);
		rd(8'h36, 8'h0F);
		HOST.acc(1'b1, 8'h56, 8'hFF);
		rd(8'h56, 8'h00);
		rd(8'h54, 8'h00);
		HOST.acc(1'b1, 8'h66, 8'h3C);
		rd(8'h66, 8'h3C);
		// Wide bus: port G belongs to the host and refuses register access
		bus_16bit = 1'b1;
		rd(8'h66, 8'h00);
		chk(pin_out[6], 8'hA5);
		chk(pin_oe_n[6], 8'h00);
		bus_16bit = 1'b0;
		HOST.acc(1'b1, 8'h04, 8'h0F);
		HOST.acc(1'b1, 8'h08, 8'hFF);
		chk(pin_oe_n[0], 8'h0F);
		repeat (2) @(negedge core_clk);
		chk(8'(q.size()), 8'h00);
		end_of_test();
	end
endmodule // mfio_ports_bench
